// ===== wdt_pkg.sv
/*
 * Constants shared by the watchdog files: register address, field layout,
 * reset values and timeout coding.
 * Assumes a core-side special-function register port on ref_clk.
 */
package wdt_pkg;
    localparam logic [7:0] WDT_CTL_ADDR = 8'hc0;
    localparam int WDT_ARM_BIT = 0;
    localparam int WDT_EN_BIT = 1;
    localparam int WDT_FLAG_BIT = 2;
    localparam int WDT_RESP_BIT = 3;
    localparam int WDT_PRE_LSB = 4;
    localparam int WDT_PRE_W = 4;
    localparam logic WDT_EN_RST = 1'b1;
    localparam logic WDT_RESP_RST = 1'b0;
    localparam logic WDT_FLAG_RST = 1'b0;
    localparam logic WDT_ARM_RST = 1'b0;
    localparam logic [3:0] WDT_PRE_RST = 4'h7;
    localparam logic [3:0] WDT_PRE_MAX_TIMED = 4'h7;
    localparam logic [3:0] WDT_PRE_ZERO_AUTO = 4'h8;
    localparam logic [3:0] WDT_PRE_ZERO_DL = 4'h9;
    // Crystal rate and the counter bit that ends the shortest period
    localparam int WDT_XTAL_HZ = 32768;
    localparam real WDT_MIN_TIMEOUT_MS = 15.6;
    localparam int WDT_CNT_W = 16;
    localparam int WDT_BASE_BIT = 9;
endpackage

// ===== wdt_edge_sync.sv
/*
 * Two-flop synchroniser with rising edge detect, giving a one-cycle enable.
 * Assumes the input toggles far slower than ref_clk.
 */
`timescale 1ns/1ps
module wdt_edge_sync (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic async_in,
    output logic rise_pulse
);
    logic sync_a;
    logic sync_b;
    logic sync_c;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign rise_pulse = sync_b & ~sync_c;
endmodule

// ===== wdt_watchdog.sv
/*
 * Watchdog timer with write arming and flash-held lock of its enable and response settings.
 * Assumes xtal_clk is the free-running 32.768 kHz crystal, flash_prot_bit
 * is the top bit of the protection byte, held stable by the flash logic,
 * and sfr_* strobes come from the core on ref_clk.
 */
`timescale 1ns/1ps
module wdt_watchdog
    import wdt_pkg::*;
#(
    parameter int CNT_W = WDT_CNT_W
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic xtal_clk,
    input wire logic flash_prot_bit,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sys_reset_req,
    output logic wd_irq
);
    logic xtal_tick;
    logic wd_enable_refresh;
    logic timeout_response_select;
    logic timeout_status_flag;
    logic write_arm_bit;
    logic [WDT_PRE_W-1:0] timeout_sel;
    logic [CNT_W-1:0] count;
    logic protected_lock;
    logic wr_ctl;
    logic ctl_accept;
    logic refresh;
    logic zero_period;
    logic timeout;

    // Terminal count of the period for a timed code
    function automatic logic [CNT_W-1:0] period_limit(input logic [WDT_PRE_W-1:0] code);
        logic [CNT_W-1:0] lim;
        lim = '1;
        if (code <= WDT_PRE_MAX_TIMED) begin
            lim = CNT_W'((32'h1 << (WDT_BASE_BIT + int'(code))) - 1);
        end
        return lim;
    endfunction

    wdt_edge_sync u_xtal_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .async_in(xtal_clk),
        .rise_pulse(xtal_tick)
    );

    assign protected_lock = ~flash_prot_bit;
    assign wr_ctl = sfr_wr && (sfr_addr == WDT_CTL_ADDR);
    assign ctl_accept = wr_ctl && write_arm_bit;
    assign refresh = ctl_accept && sfr_wdata[WDT_EN_BIT];
    assign zero_period = (timeout_sel == WDT_PRE_ZERO_AUTO) ||
                         (timeout_sel == WDT_PRE_ZERO_DL);
    // Codes above the zero-period ones fall back to the longest period
    // A refresh in its own cycle never counts as a miss
    assign timeout = wd_enable_refresh && !refresh &&
                     (zero_period || (xtal_tick && count == period_limit(timeout_sel)));

    // Arming state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            write_arm_bit <= WDT_ARM_RST;
        end else if (sfr_wr) begin
            if (wr_ctl && !write_arm_bit) begin
                write_arm_bit <= sfr_wdata[WDT_ARM_BIT];
            end else begin
                write_arm_bit <= 1'b0;
            end
        end
    end

    // Settings
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wd_enable_refresh <= WDT_EN_RST;
            timeout_response_select <= WDT_RESP_RST;
            timeout_sel <= WDT_PRE_RST;
        end else begin
            if (ctl_accept) begin
                timeout_sel <= sfr_wdata[WDT_PRE_LSB +: WDT_PRE_W];
            end
            if (protected_lock) begin
                wd_enable_refresh <= 1'b1;
                timeout_response_select <= 1'b0;
            end else if (ctl_accept) begin
                wd_enable_refresh <= sfr_wdata[WDT_EN_BIT];
                timeout_response_select <= sfr_wdata[WDT_RESP_BIT];
            end
        end
    end

    // Status flag, a timeout wins over a clearing write
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timeout_status_flag <= WDT_FLAG_RST;
        end else if (timeout) begin
            timeout_status_flag <= 1'b1;
        end else if (ctl_accept && !sfr_wdata[WDT_FLAG_BIT]) begin
            timeout_status_flag <= 1'b0;
        end
    end

    // Counter on crystal ticks
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (!wd_enable_refresh || refresh || timeout) begin
            count <= '0;
        end else if (xtal_tick) begin
            count <= count + 1'b1;
        end
    end

    // Response outputs, one-cycle pulses for timed codes, high every timeout cycle for zero-period codes
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sys_reset_req <= 1'b0;
            wd_irq <= 1'b0;
        end else begin
            sys_reset_req <= timeout && !timeout_response_select;
            wd_irq <= timeout && timeout_response_select;
        end
    end

    // Read data
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= {timeout_sel, timeout_response_select, timeout_status_flag,
                          wd_enable_refresh, write_arm_bit};
        end
    end

    a_prot_forces_cfg: assert property (@(posedge ref_clk) disable iff (!arst_n)
        protected_lock |=> wd_enable_refresh && !timeout_response_select)
        else $error("Protection did not force settings");
    a_unarmed_write_ignored: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_ctl && !write_arm_bit |=> $stable(timeout_sel))
        else $error("Unarmed write changed timeout select");
    a_arm_expires_next: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sfr_wr && write_arm_bit |=> !write_arm_bit)
        else $error("Arming outlived a write");
    a_timeout_sets_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
        timeout |=> timeout_status_flag)
        else $error("Timeout flag not set");
    a_resp_reset_path: assert property (@(posedge ref_clk) disable iff (!arst_n)
        timeout && !timeout_response_select |=> sys_reset_req && !wd_irq)
        else $error("Reset response missing");
    a_resp_irq_path: assert property (@(posedge ref_clk) disable iff (!arst_n)
        timeout && timeout_response_select |=> wd_irq && !sys_reset_req)
        else $error("Interrupt response missing");
    a_refresh_clears_cnt: assert property (@(posedge ref_clk) disable iff (!arst_n)
        refresh |=> count == '0)
        else $error("Refresh did not clear counter");
    a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !wd_enable_refresh |-> !timeout ##1 !sys_reset_req && !wd_irq)
        else $error("Disabled watchdog timed out");
    a_flag_clear_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctl_accept && !sfr_wdata[WDT_FLAG_BIT] && !timeout |=> !timeout_status_flag)
        else $error("Flag not cleared by written zero");
    a_period_end_bit: assert property (@(posedge ref_clk) disable iff (!arst_n)
        timeout && !zero_period && timeout_sel <= WDT_PRE_MAX_TIMED
        |-> count == ({CNT_W{1'b1}} >> (CNT_W - WDT_BASE_BIT - int'(timeout_sel))))
        else $error("Timeout at wrong counter value");
    a_tick_advances: assert property (@(posedge ref_clk) disable iff (!arst_n)
        xtal_tick && wd_enable_refresh && !refresh && !timeout
        |=> count == $past(count) + 1'b1)
        else $error("Counter did not advance on tick");

    // Register and response cross-checks
    a_arm_write_sets: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_ctl && !write_arm_bit && sfr_wdata[WDT_ARM_BIT] |=> write_arm_bit)
        else $error("Arming write did not arm");
    a_unarmed_keeps_cfg: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_ctl && !write_arm_bit && !protected_lock
        |=> $stable(wd_enable_refresh) && $stable(timeout_response_select))
        else $error("Unarmed write changed enable or response");
    a_flag_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
        timeout_status_flag && !(ctl_accept && !sfr_wdata[WDT_FLAG_BIT])
        |=> timeout_status_flag)
        else $error("Timeout flag lost without a clearing write");
    a_flag_written_one: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctl_accept && sfr_wdata[WDT_FLAG_BIT] && !timeout |=> $stable(timeout_status_flag))
        else $error("Written one changed the flag");
    a_timed_needs_tick: assert property (@(posedge ref_clk) disable iff (!arst_n)
        timeout && !zero_period |-> xtal_tick)
        else $error("Timed period ended without a crystal tick");
    a_count_held_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !wd_enable_refresh |=> count == '0)
        else $error("Counter ran while disabled");
    a_zero_code_fires: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wd_enable_refresh && zero_period && !refresh |=> sys_reset_req || wd_irq)
        else $error("Zero-period code did not time out");
    a_pulse_has_cause: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sys_reset_req || wd_irq |-> $past(timeout))
        else $error("Response pulse without a timeout");
    a_response_exclusive: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !(sys_reset_req && wd_irq))
        else $error("Reset and interrupt raised together");
endmodule

// ===== wdt_watchdog_test.sv
/*
 * Self-checking bench for the watchdog: control register model, arming, lock, timeouts.
 * Assumes wdt_pkg and wdt_watchdog compiled first; xtal_clk sped up to 8 ref_clk cycles.
 */
`timescale 1ns/1ps
module wdt_watchdog_test;
    import wdt_pkg::*;
    logic ref_clk = 0, arst_n = 0, xtal_clk = 0, flash_prot_bit = 1, sfr_wr = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, m_reg = 8'h72;
    logic [7:0] sfr_rdata;
    logic sys_reset_req, wd_irq;
    logic [31:0] lfsr = 32'hc565;
    int miscompares = 0, cmp_count = 0, cyc = 0, ticks = 0, n_rst = 0, n_irq = 0, t_wr = 0;
    wdt_watchdog u_wdt_watchdog (.ref_clk(ref_clk), .arst_n(arst_n), .xtal_clk(xtal_clk),
        .flash_prot_bit(flash_prot_bit), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sys_reset_req(sys_reset_req),
        .wd_irq(wd_irq));
    initial forever #50 ref_clk = ~ref_clk;
    initial forever #400 xtal_clk = ~xtal_clk;
    always @(posedge xtal_clk) ticks++;
    always @(posedge ref_clk) begin
        cyc++;
        if (sys_reset_req === 1'b1) n_rst++;
        if (wd_irq === 1'b1) n_irq++;
        if (cyc == 50000) begin
            miscompares++;
            results();
        end
    end
    task automatic check(string name, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // One write cycle plus the model's view of it
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        #1 sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        @(posedge ref_clk);
        #1 sfr_wr = 0;
        if (a == WDT_CTL_ADDR && m_reg[0]) m_reg = {d[7:3], m_reg[2] & d[2], d[1], 1'b0};
        else if (a == WDT_CTL_ADDR) m_reg[0] = d[0];
        else m_reg[0] = 1'b0;
        if (!flash_prot_bit) m_reg[3:1] = {1'b0, m_reg[2], 1'b1};
        t_wr = ticks;
    endtask
    task automatic cfg(logic [7:0] d);
        wr(WDT_CTL_ADDR, 8'h01);
        wr(WDT_CTL_ADDR, d);
    endtask
    task automatic chk_reg();
        repeat (2) @(posedge ref_clk);
        #1 check("sfr_rdata", m_reg, sfr_rdata);
    endtask
    task automatic run_to(int exp, logic want_irq);
        int r0, i0, d;
        r0 = n_rst;
        i0 = n_irq;
        while (n_rst == r0 && n_irq == i0 && ticks - t_wr < exp + 8) begin
            @(posedge ref_clk);
            #1;
        end
        d = ticks - t_wr;
        check("timeout_in_window", 1, (d + 1 >= exp && d <= exp));
        check("irq_seen", want_irq, n_irq != i0);
        check("reset_seen", !want_irq, n_rst != r0);
        repeat (3) @(posedge ref_clk);
        #1 check("pulse_count", 1, n_rst - r0 + n_irq - i0);
        m_reg[2] = 1'b1;
        chk_reg();
    endtask
    task automatic results();
        $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        int r0;
        repeat (20) @(posedge ref_clk);
        #1 arst_n = 1;
        chk_reg();
        wr(WDT_CTL_ADDR, 8'h70);
        chk_reg();
        wr(WDT_CTL_ADDR, 8'h01);
        lfsr = lfsr_next(lfsr);
        wr((lfsr[7:0] == WDT_CTL_ADDR) ? 8'hc1 : lfsr[7:0], lfsr[15:8]);
        wr(WDT_CTL_ADDR, 8'h70);
        chk_reg();
        cfg(8'h00);
        chk_reg();
        r0 = n_rst + n_irq;
        while (ticks - t_wr < 600) @(posedge ref_clk);
        check("pulses_disabled", r0, n_rst + n_irq);
        cfg(8'h02);
        while (ticks - t_wr < 300) @(posedge ref_clk);
        cfg(8'h02);
        run_to(512, 1'b0);
        cfg(8'h1e);
        run_to(1024, 1'b1);
        cfg(8'h00);
        chk_reg();
        flash_prot_bit = 0;
        m_reg[3:1] = {1'b0, m_reg[2], 1'b1};
        cfg(8'h08);
        run_to(512, 1'b0);
        flash_prot_bit = 1;
        // Zero-period code: a timeout every cycle while enabled
        cfg(8'h82);
        r0 = n_rst;
        m_reg[2] = 1'b1;
        chk_reg();
        repeat (3) @(posedge ref_clk);
        #1 check("zero_period_pulses", 4, n_rst - r0);
        // Disabling write lands in a timeout cycle, the set wins
        cfg(8'h00);
        m_reg[2] = 1'b1;
        chk_reg();
        // External reset mid-run clears the flag and restores defaults
        arst_n = 0;
        m_reg = 8'h72;
        repeat (3) @(posedge ref_clk);
        #1 arst_n = 1;
        chk_reg();
        results();
    end
endmodule
